// ===== npc_comms_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module npc_comms_ctrl
	import npc_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      arst_n,
	input  wire logic [npc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [npc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [npc_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic [1:0]                time_phase,
	output logic                           tx_valid,
	input  wire logic                      tx_ready,
	output logic      [npc_pkg::PKT_W-1:0]  tx_packet,
	input  wire logic                      rx_valid,
	output logic                           rx_ready,
	input  wire logic [npc_pkg::PKT_W-1:0]  rx_packet,
	output logic                           rx_irq
);

	import npc_pkg::*;

	typedef enum logic [0:0] {
		RX_EMPTY,
		RX_HELD
	} npc_rx_state_t;

	// ======================================================================
	// functions

	// receive key: a multicast key as sent, or the sender's identifier and sequence code of a point-to-point packet
	function automatic logic [DATA_W-1:0] npc_rx_key(input logic [PKT_W-1:0] pkt);
		logic [CB_W-1:0]   cb;
		logic [DATA_W-1:0] key;
		logic [DATA_W-1:0] res;
		cb  = pkt[PKT_CTRL_LSB +: CB_W];
		key = pkt[PKT_KEY_LSB +: DATA_W];
		res = '0;
		if (cb[CB_TYPE] == TYPE_MULTICAST) begin
			res = key;
		end else begin
			res[SC_ID_LSB +: SC_ID_W] = key[P2P_SRC_LSB +: SC_ID_W];
			res[SK_SEQ_LSB +: 2]      = cb[CB_SEQ_LSB +: 2];
		end
		return res;
	endfunction

	function automatic logic npc_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// ======================================================================
	// configuration state
	logic [SC_ID_W-1:0] own_chip_identifier;
	logic               multicast_kind;
	logic               spare_value;
	logic               int_enable;
	logic [SC_ID_W-1:0] next_own_chip_identifier;
	logic               next_multicast_kind;
	logic               next_spare_value;
	logic               next_int_enable;

	logic               wr_status;
	logic               wr_payload;
	logic               wr_key;
	logic               rd_rx_key;

	always_comb begin
		wr_status = reg_wr && npc_hit(reg_addr, OFS_STATUS_CONTROL);
		wr_payload = reg_wr && npc_hit(reg_addr, OFS_SEND_PAYLOAD);
		wr_key = reg_wr && npc_hit(reg_addr, OFS_SEND_KEY_LAUNCH);
		rd_rx_key = reg_rd && npc_hit(reg_addr, OFS_RECEIVE_KEY);
	end

	always_comb begin
		next_own_chip_identifier = own_chip_identifier;
		next_multicast_kind      = multicast_kind;
		next_spare_value         = spare_value;
		next_int_enable          = int_enable;
		if (wr_status) begin
			next_own_chip_identifier = reg_wdata[SC_ID_LSB +: SC_ID_W];
			next_multicast_kind      = reg_wdata[SC_KIND_BIT];
			next_spare_value         = reg_wdata[SC_SPARE_BIT];
			next_int_enable          = reg_wdata[SC_IEN_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			own_chip_identifier <= RST_OWN_CHIP_IDENTIFIER;
			multicast_kind      <= RST_KIND;
			spare_value         <= RST_SPARE;
			int_enable          <= RST_IEN;
		end else begin
			own_chip_identifier <= next_own_chip_identifier;
			multicast_kind      <= next_multicast_kind;
			spare_value         <= next_spare_value;
			int_enable          <= next_int_enable;
		end
	end

	// ======================================================================
	// transmit side
	logic [DATA_W-1:0] send_payload;
	logic              payload_armed;
	logic              tx_full;
	logic [PKT_W-1:0]  tx_hold;
	logic [DATA_W-1:0] next_send_payload;
	logic              next_payload_armed;
	logic              next_tx_full;
	logic [PKT_W-1:0]  next_tx_hold;
	logic              tx_leaving;
	logic              launch;
	logic [PKT_W-1:0]  tx_build;
	logic [CB_W-1:0]   tx_cb;
	logic [DATA_W-1:0] tx_key;
	logic              tx_fill;

	npc_parity #(
		.PKT_W  (PKT_W),
		.PAY_LSB(PKT_PAY_LSB),
		.PAR_BIT(PKT_CTRL_LSB + CB_PARITY)
	) u_tx_parity (
		.packet     (tx_build),
		.has_payload(payload_armed),
		.odd_fill   (tx_fill)
	);

	// control byte and key of a packet launched from the current settings
	always_comb begin
		tx_cb               = '0;
		tx_cb[CB_SPARE]     = spare_value;
		tx_cb[CB_STAMP_LSB +: 2] = time_phase;
		tx_cb[CB_DATA]      = payload_armed;
		tx_key              = '0;
		if (multicast_kind) begin
			tx_cb[CB_TYPE]         = TYPE_MULTICAST;
			tx_cb[CB_SEQ_LSB +: 2] = EMERGENCY_NORMAL;
			tx_key                 = reg_wdata;
		end else begin
			tx_cb[CB_TYPE]         = TYPE_POINT_TO_POINT;
			tx_cb[CB_SEQ_LSB +: 2] = reg_wdata[SK_SEQ_LSB +: 2];
			tx_key[P2P_DEST_LSB +: SC_ID_W] = reg_wdata[P2P_DEST_LSB +: SC_ID_W];
			tx_key[P2P_SRC_LSB +: SC_ID_W]  = own_chip_identifier;
		end
		tx_build = '0;
		tx_build[PKT_CTRL_LSB +: CB_W] = tx_cb;
		tx_build[PKT_KEY_LSB +: DATA_W] = tx_key;
		if (payload_armed) begin
			tx_build[PKT_PAY_LSB +: DATA_W] = send_payload;
		end
	end

	always_comb begin
		tx_leaving         = tx_full && tx_ready;
		// a key written while the slot is occupied and tx_ready is low is dropped
		launch             = wr_key && (!tx_full || tx_ready);
		next_send_payload  = send_payload;
		next_payload_armed = payload_armed;
		next_tx_full       = tx_full;
		next_tx_hold       = tx_hold;
		if (tx_leaving) begin
			next_tx_full = 1'b0;
		end
		if (launch) begin
			next_tx_full = 1'b1;
			next_tx_hold = tx_build;
			next_tx_hold[PKT_CTRL_LSB + CB_PARITY] = tx_fill;
			next_payload_armed = 1'b0;
		end
		if (wr_payload) begin
			next_send_payload  = reg_wdata;
			next_payload_armed = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			send_payload  <= RST_WORD;
			payload_armed <= 1'b0;
			tx_full       <= 1'b0;
			tx_hold       <= '0;
		end else begin
			send_payload  <= next_send_payload;
			payload_armed <= next_payload_armed;
			tx_full       <= next_tx_full;
			tx_hold       <= next_tx_hold;
		end
	end

	always_comb begin
		tx_valid  = tx_full;
		tx_packet = tx_hold;
	end

	// ======================================================================
	// receive side
	npc_rx_state_t     rx_state;
	npc_rx_state_t     next_rx_state;
	logic [DATA_W-1:0] receive_payload;
	logic [DATA_W-1:0] receive_key;
	logic [CB_W-1:0]   rx_ctrl;
	logic              rx_parity_err;
	logic [DATA_W-1:0] next_receive_payload;
	logic [DATA_W-1:0] next_receive_key;
	logic [CB_W-1:0]   next_rx_ctrl;
	logic              next_rx_parity_err;
	logic              rx_take;
	logic              rx_fill;
	logic              rx_has_payload;
	logic              received;
	logic              int_pending;

	always_comb begin
		rx_has_payload = rx_packet[PKT_CTRL_LSB + CB_DATA];
	end

	npc_parity #(
		.PKT_W  (PKT_W),
		.PAY_LSB(PKT_PAY_LSB),
		.PAR_BIT(PKT_CTRL_LSB + CB_PARITY)
	) u_rx_parity (
		.packet     (rx_packet),
		.has_payload(rx_has_payload),
		.odd_fill   (rx_fill)
	);

	always_comb begin
		// a new packet is taken only after the receive key of the held one has been read
		rx_ready             = (rx_state == RX_EMPTY);
		rx_take              = rx_valid && rx_ready;
		next_rx_state        = rx_state;
		next_receive_payload = receive_payload;
		next_receive_key     = receive_key;
		next_rx_ctrl         = rx_ctrl;
		next_rx_parity_err   = rx_parity_err;
		unique case (rx_state)
			RX_EMPTY: begin
				if (rx_take) begin
					next_rx_state      = RX_HELD;
					next_receive_key   = npc_rx_key(rx_packet);
					next_rx_ctrl       = rx_packet[PKT_CTRL_LSB +: CB_W];
					next_rx_parity_err = rx_packet[PKT_CTRL_LSB + CB_PARITY] != rx_fill;
					if (rx_has_payload) begin
						next_receive_payload = rx_packet[PKT_PAY_LSB +: DATA_W];
					end
				end
			end
			RX_HELD: begin
				if (rd_rx_key) begin
					next_rx_state = RX_EMPTY;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_state        <= RX_EMPTY;
			receive_payload <= RST_WORD;
			receive_key     <= RST_WORD;
			rx_ctrl         <= '0;
			rx_parity_err   <= 1'b0;
		end else begin
			rx_state        <= next_rx_state;
			receive_payload <= next_receive_payload;
			receive_key     <= next_receive_key;
			rx_ctrl         <= next_rx_ctrl;
			rx_parity_err   <= next_rx_parity_err;
		end
	end

	always_comb begin
		received    = (rx_state == RX_HELD);
		int_pending = received && int_enable;
		rx_irq      = int_pending;
	end

	// ======================================================================
	// register read port
	logic [DATA_W-1:0] next_reg_rdata;
	logic [DATA_W-1:0] status_word;

	always_comb begin
		status_word                            = '0;
		status_word[SC_ID_LSB +: SC_ID_W]      = own_chip_identifier;
		status_word[SC_CTRL_LSB +: CB_W]       = rx_ctrl;
		status_word[SC_KIND_BIT]               = multicast_kind;
		status_word[SC_TXFULL_BIT]             = tx_full;
		status_word[SC_SPARE_BIT]              = spare_value;
		status_word[SC_PERR_BIT]               = rx_parity_err;
		status_word[SC_RXD_BIT]                = received;
		status_word[SC_IEN_BIT]                = int_enable;
		status_word[SC_IPEND_BIT]              = int_pending;
	end

	always_comb begin
		next_reg_rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_STATUS_CONTROL:  next_reg_rdata = status_word;
				OFS_RECEIVE_PAYLOAD: next_reg_rdata = receive_payload;
				OFS_RECEIVE_KEY:     next_reg_rdata = receive_key;
				default:             next_reg_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

endmodule

`default_nettype wire

// ===== npc_pkg.sv
package npc_pkg;

	// ======================================================================
	// bus geometry
	localparam int                 ADDR_W                  = 8;
	localparam int                 DATA_W                  = 32;

	// ======================================================================
	// register byte offsets
	localparam logic [ADDR_W-1:0]  OFS_STATUS_CONTROL      = 8'h00;
	localparam logic [ADDR_W-1:0]  OFS_SEND_PAYLOAD        = 8'h08;
	localparam logic [ADDR_W-1:0]  OFS_SEND_KEY_LAUNCH     = 8'h0c;
	localparam logic [ADDR_W-1:0]  OFS_RECEIVE_PAYLOAD     = 8'h10;
	localparam logic [ADDR_W-1:0]  OFS_RECEIVE_KEY         = 8'h14;

	// ======================================================================
	// status/control field positions
	localparam int                 SC_ID_LSB               = 0;
	localparam int                 SC_ID_W                 = 16;
	localparam int                 SC_CTRL_LSB             = 16;
	localparam int                 SC_KIND_BIT             = 25;
	localparam int                 SC_TXFULL_BIT           = 26;
	localparam int                 SC_SPARE_BIT            = 27;
	localparam int                 SC_PERR_BIT             = 28;
	localparam int                 SC_RXD_BIT              = 29;
	localparam int                 SC_IEN_BIT              = 30;
	localparam int                 SC_IPEND_BIT            = 31;

	// ======================================================================
	// reset values
	localparam logic [SC_ID_W-1:0] RST_OWN_CHIP_IDENTIFIER = 16'h0000;
	localparam logic               RST_KIND                = 1'b0;
	localparam logic               RST_SPARE               = 1'b0;
	localparam logic               RST_IEN                 = 1'b0;
	localparam logic [DATA_W-1:0]  RST_WORD                = 32'h0000_0000;

	// ======================================================================
	// control byte layout
	localparam int                 CB_W                    = 8;
	localparam int                 CB_PARITY               = 0;
	localparam int                 CB_SPARE                = 1;
	localparam int                 CB_STAMP_LSB            = 2;
	localparam int                 CB_SEQ_LSB              = 4;
	localparam int                 CB_DATA                 = 6;
	localparam int                 CB_TYPE                 = 7;
	localparam logic               TYPE_MULTICAST          = 1'b0;
	localparam logic               TYPE_POINT_TO_POINT     = 1'b1;
	localparam logic [1:0]         EMERGENCY_NORMAL        = 2'h0;

	// ======================================================================
	// packet layout: {payload, key, control}
	localparam int                 PKT_W                   = 72;
	localparam int                 PKT_CTRL_LSB            = 0;
	localparam int                 PKT_KEY_LSB             = 8;
	localparam int                 PKT_PAY_LSB             = 40;
	localparam int                 P2P_DEST_LSB            = 0;
	localparam int                 P2P_SRC_LSB             = 16;
	localparam int                 SK_SEQ_LSB              = 16;

endpackage

// ===== npc_parity.sv
`timescale 1ns/10ps
`default_nettype none

// computes the parity bit that makes a packet odd, ignoring its own
// parity position and the payload field when no payload is present
module npc_parity #(
	parameter int PKT_W = 72,
	parameter int PAY_LSB = 40,
	parameter int PAR_BIT = 0
) (
	input  wire logic [PKT_W-1:0] packet,
	input  wire logic             has_payload,
	output logic                  odd_fill
);

	logic [PKT_W-1:0] masked;

	always_comb begin
		masked          = packet;
		masked[PAR_BIT] = 1'b0;
		if (!has_payload) begin
			masked[PKT_W-1:PAY_LSB] = '0;
		end
		odd_fill = ~(^masked);
	end

endmodule

`default_nettype wire

// ===== npc_checker.sv
`timescale 1ns/10ps
`default_nettype none

module npc_checker
	import npc_pkg::*;
(
	input wire logic                       sys_clk,
	input wire logic                       arst_n,
	input wire logic [npc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [npc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [npc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [1:0]                 time_phase,
	input wire logic                       tx_valid,
	input wire logic                       tx_ready,
	input wire logic [npc_pkg::PKT_W-1:0]  tx_packet,
	input wire logic                       rx_valid,
	input wire logic                       rx_ready,
	input wire logic [npc_pkg::PKT_W-1:0]  rx_packet,
	input wire logic                       rx_irq
);
	logic key_wr;
	logic rkey_rd;
	assign key_wr = reg_wr && reg_addr == OFS_SEND_KEY_LAUNCH;
	assign rkey_rd = reg_rd && reg_addr == OFS_RECEIVE_KEY;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// ==========
	// transmit side
	AST_LAUNCH: assert property (key_wr && !tx_valid |=> tx_valid)
		else $error("key write gave no packet");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_packet))
		else $error("offered packet changed before acceptance");
	AST_TX_STAMP: assert property (key_wr && !tx_valid |=> tx_packet[3:2] == $past(time_phase))
		else $error("stamp differs from phase at launch");
	AST_TX_PARITY: assert property (tx_valid |-> ^tx_packet)
		else $error("sent packet has even parity");
	AST_TX_NOPAY: assert property (tx_valid && !tx_packet[CB_DATA] |-> tx_packet[71:40] == 32'h0)
		else $error("payload field set without payload flag");
	AST_TX_MCCODE: assert property (tx_valid && tx_packet[CB_TYPE] == TYPE_MULTICAST |-> tx_packet[5:4] == 2'h0)
		else $error("multicast packet with nonzero code");
	// ==========
	// receive side
	AST_RX_TAKE: assert property (rx_valid && rx_ready |=> !rx_ready)
		else $error("ready stayed high after taking a packet");
	AST_RX_HOLD: assert property (!rx_ready && !rkey_rd |=> !rx_ready)
		else $error("held packet released without key read");
	AST_RX_FREE: assert property (rkey_rd && !rx_ready |=> rx_ready && !rx_irq)
		else $error("key read did not free the receiver");
	AST_IRQ: assert property (rx_irq |-> !rx_ready)
		else $error("interrupt without held packet");
	cover property (tx_valid && tx_ready);
	cover property (key_wr && tx_valid && !tx_ready);
	cover property (rx_irq && rkey_rd);
endmodule

bind npc_comms_ctrl npc_checker chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .time_phase(time_phase), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_packet(tx_packet), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.rx_packet(rx_packet), .rx_irq(rx_irq)
);
`default_nettype wire

// ===== npc_net_model.sv
`timescale 1ns/10ps
`default_nettype none

// network side: stall 0 prompt, 1 random, 2 stopped
module npc_net_model
	import npc_pkg::*;
(
	input wire logic                       sys_clk,
	input wire logic                       arst_n,
	input wire logic [1:0]                 stall,
	input wire logic                       tx_valid,
	output logic                           tx_ready,
	input wire logic [npc_pkg::PKT_W-1:0]  tx_packet,
	output logic                           rx_valid,
	input wire logic                       rx_ready,
	output logic     [npc_pkg::PKT_W-1:0]  rx_packet
);
	logic [PKT_W-1:0] got[$];
	logic [PKT_W-1:0] pend[$];
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_packet = '0;
	end
	always @(posedge sys_clk) begin
		if (arst_n && tx_valid && tx_ready) begin
			got.push_back(tx_packet);
		end
		tx_ready <= (stall == 2'h0) || (stall == 2'h1 && $urandom_range(0, 2) == 0);
		if (rx_valid && rx_ready) begin
			rx_valid <= 1'b0;
			void'(pend.pop_front());
		end else if (!rx_valid && pend.size() > 0) begin
			rx_valid <= 1'b1;
			rx_packet <= pend[0];
		end
		// a released bus never keeps its last value
		if (!rx_valid || rx_ready) begin
			if (!(!rx_valid && pend.size() > 0)) begin
				rx_packet <= ~rx_packet;
			end
		end
	end
endmodule
`default_nettype wire

// ===== test_neural_packet_comms_controller.sv
`timescale 1ns/10ps
`default_nettype none

module test_neural_packet_comms_controller;
	import npc_pkg::*;
	logic               sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [ADDR_W-1:0]  reg_addr = 8'h00;
	logic [DATA_W-1:0]  reg_wdata = 32'h0, reg_rdata, sc, key, pay, rpay, rkey;
	logic [1:0]         time_phase = 2'h0, stall = 2'h0;
	logic               tx_valid, tx_ready, rx_valid, rx_ready, rx_irq, rcvd, perr, armed;
	logic [7:0]         cbyte;
	logic [PKT_W-1:0]   tx_packet, rx_packet, got, pk[2];
	int                 failures = 0, total_checks = 0;

	always #10 sys_clk = ~sys_clk;

	npc_comms_ctrl dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .time_phase(time_phase), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_packet(tx_packet), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_packet(rx_packet), .rx_irq(rx_irq)
	);
	npc_net_model net (
		.sys_clk(sys_clk), .arst_n(arst_n), .stall(stall), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_packet(tx_packet), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_packet(rx_packet)
	);

	// ==========
	// bus cycles and comparison
	task automatic chk(input logic [PKT_W-1:0] e, input logic [PKT_W-1:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(PKT_W'(e), PKT_W'(reg_rdata));
	endtask
	task automatic tx_chk(input logic [PKT_W-1:0] e);
		for (int n = 0; n < 200 && net.got.size() == 0; n++) @(posedge sys_clk);
		got = (net.got.size() > 0) ? net.got.pop_front() : 'x;
		chk(e, got);
	endtask
	task automatic report_and_stop();
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========
	// reference model
	function automatic logic [DATA_W-1:0] st_exp(input logic full);
		return {rcvd & sc[30], sc[30], rcvd, perr, sc[27], full, sc[25], 1'b0, cbyte, sc[15:0]};
	endfunction
	function automatic logic [PKT_W-1:0] tx_exp(input logic [DATA_W-1:0] k, input logic [1:0] ph,
			input logic hp, input logic [DATA_W-1:0] p);
		logic [PKT_W-1:0] e;
		e[71:40] = hp ? p : 32'h0;
		e[39:8] = sc[25] ? k : {sc[15:0], k[15:0]};
		e[7:0] = {~sc[25], hp, sc[25] ? 2'h0 : k[17:16], ph, sc[27], 1'b0};
		e[0] = ~^e;
		return e;
	endfunction
	// j bit 0 type, bit 1 payload, bit 2 deliberate parity fault
	function automatic logic [PKT_W-1:0] rx_make(input int j);
		logic [PKT_W-1:0] k;
		k = {$urandom, $urandom, 8'($urandom)};
		k[7] = j[0];
		k[6] = j[1];
		k[0] = ~(^k[39:1] ^ (k[6] & ^k[71:40])) ^ j[2];
		return k;
	endfunction

	initial begin
		#200000;
		// far beyond the few hundred cycles the tests need
		failures++;
		report_and_stop();
	end

	initial begin
		void'($urandom(24901));
		{rcvd, perr, armed, cbyte, rpay, sc} = '0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		wr(8'h04, 32'hffff_ffff);
		wr(OFS_RECEIVE_KEY, 32'hffff_ffff);
		rchk(OFS_STATUS_CONTROL, st_exp(1'b0));
		rchk(8'h04, 32'h0);
		rchk(OFS_SEND_PAYLOAD, 32'h0);
		rchk(OFS_RECEIVE_KEY, 32'h0);
		chk(PKT_W'(2'b10), PKT_W'({rx_ready, tx_valid}));
		for (int i = 0; i < 12; i++) begin
			key = $urandom;
			key[25] = i[2] ^ i[0];
			// own identifier stays as first programmed
			if (i > 0) key[15:0] = sc[15:0];
			wr(OFS_STATUS_CONTROL, key);
			sc = key & 32'h4a00_ffff;
			rchk(OFS_STATUS_CONTROL, st_exp(1'b0));
			@(posedge sys_clk);
			stall <= {1'b0, i[0]};
			time_phase <= {i[1], i[1] ^ i[0]};
			pay = $urandom;
			key = $urandom;
			key[17:16] = i[1:0];
			armed = (i[2:1] != 2'b00);
			if (armed) wr(OFS_SEND_PAYLOAD, pay);
			wr(OFS_SEND_KEY_LAUNCH, key);
			tx_chk(tx_exp(key, {i[1], i[1] ^ i[0]}, armed, pay));
		end
		stall <= 2'h2;
		wr(OFS_SEND_KEY_LAUNCH, key);
		rchk(OFS_STATUS_CONTROL, st_exp(1'b1));
		wr(OFS_SEND_KEY_LAUNCH, ~key);
		stall <= 2'h0;
		tx_chk(tx_exp(key, time_phase, 1'b0, pay));
		repeat (4) @(posedge sys_clk);
		chk(PKT_W'(0), PKT_W'(net.got.size()));
		for (int j = 0; j < 8; j++) begin
			if (j % 4 == 0) begin
				sc[30] = (j == 0);
				wr(OFS_STATUS_CONTROL, sc);
			end
			if (!j[0]) begin
				pk[0] = rx_make(j);
				pk[1] = rx_make(j + 1);
				net.pend.push_back(pk[0]);
				net.pend.push_back(pk[1]);
			end
			got = pk[j % 2];
			for (int n = 0; n < 50 && rx_ready !== 1'b0; n++) @(posedge sys_clk);
			repeat (2) @(posedge sys_clk);
			rcvd = 1'b1;
			cbyte = got[7:0];
			perr = j[2];
			if (got[6]) rpay = got[71:40];
			rkey = got[7] ? {14'h0, got[5:4], got[39:24]} : got[39:8];
			rchk(OFS_STATUS_CONTROL, st_exp(1'b0));
			chk(PKT_W'(sc[30]), PKT_W'(rx_irq));
			rchk(OFS_RECEIVE_PAYLOAD, rpay);
			rchk(OFS_RECEIVE_KEY, rkey);
			rcvd = 1'b0;
			if (j[0]) rchk(OFS_STATUS_CONTROL, st_exp(1'b0));
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
